// file: asp_uart_top.sv
// two asynchronous serial channels with queues, flow control, infrared and rs485
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.svh"
module asp_uart_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] div_x_en,
  input wire logic [1:0] div_x_one,
  input wire logic [1:0][3:0] divider_x,
  input wire logic [1:0][15:0] baud_divisor_field,
  input wire logic [1:0][1:0] function_select_register,
  input wire logic [1:0] parity_en,
  input wire logic [1:0] flow_auto_en,
  input wire logic [1:0][3:0] flow_trigger_level,
  input wire logic [1:0][3:0] rx_trigger_level,
  input wire logic [1:0][7:0] rx_tout_bits,
  input wire logic [1:0][5:0] irq_en,
  input wire logic [1:0][4:0] status_clr,
  input wire logic [1:0][8:0] tx_data,
  input wire logic [1:0] tx_valid,
  output wire logic [1:0] tx_ready,
  output wire logic [1:0][8:0] rx_data,
  output wire logic [1:0] rx_valid,
  input wire logic [1:0] rx_ready,
  input wire logic [1:0] ser_in,
  output wire logic [1:0] ser_out,
  input wire logic [1:0] cts_n,
  output wire logic [1:0] rts_n,
  output wire logic [1:0][3:0] err_flags,
  output wire logic [1:0][5:0] irq_src,
  output wire logic [1:0] tx_busy,
  output wire logic [1:0] rx_busy,
  output logic uart_irq_ff
);
  logic [1:0] ch_irq;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      uart_irq_ff <= 1'b0;
    end else begin
      uart_irq_ff <= |ch_irq;
    end
  end

  for (genvar g = 0; g < `ASP_CHANNELS; g++) begin : ch
    asp_stream_if #(.W(`ASP_WORD_W), .D(`ASP_FIFO_DEPTH)) tx_q ();
    asp_stream_if #(.W(`ASP_WORD_W), .D(`ASP_FIFO_DEPTH)) rx_q ();
    logic tick;
    logic [16:0] bit_len;
    logic in_s1_ff, in_s2_ff, in_s3_ff, in_filt_ff;
    logic cts_s1_ff, cts_s2_ff, cts_s3_ff, cts_filt_ff, cts_prev_ff;
    logic irda, rs485, use_par, rx_line;
    logic [3:0] nbits;
    logic [16:0] half_len, ir_len, ir_hold_ff;
    asp_pkg::asp_tx_state_e tx_state_ff;
    logic [8:0] tx_shift_ff;
    logic [3:0] tx_bit_ff;
    logic [16:0] tx_cnt_ff;
    logic tx_line_ff, tx_par_ff, tx_take, tx_end, ser_out_ff;
    asp_pkg::asp_rx_state_e rx_state_ff;
    logic [8:0] rx_shift_ff, rx_word_ff;
    logic [3:0] rx_bit_ff;
    logic [16:0] rx_cnt_ff;
    logic rx_par_ff, rx_zero_ff, rx_perr_ff, rx_push_ff, rx_mid, rx_end;
    logic [3:0] err_ff, err_set;
    logic modem_ff, rts_n_ff;
    logic [16:0] tout_tick_ff;
    logic [7:0] tout_bits_ff;
    logic [5:0] src, src_ff;
    logic [1:0] busy_ff;

    asp_baud u_baud (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .div_x_en(div_x_en[g]),
      .div_x_one(div_x_one[g]),
      .divider_x(divider_x[g]),
      .baud_divisor_field(baud_divisor_field[g]),
      .tick_ff(tick),
      .bit_len_ff(bit_len)
    );
    asp_fifo #(.W(`ASP_WORD_W), .D(`ASP_FIFO_DEPTH)) u_txq (.clk_sys(clk_sys), .rst_n(rst_n), .q(tx_q.fifo));
    asp_fifo #(.W(`ASP_WORD_W), .D(`ASP_FIFO_DEPTH)) u_rxq (.clk_sys(clk_sys), .rst_n(rst_n), .q(rx_q.fifo));

    assign tx_q.wr_valid = tx_valid[g];
    assign tx_q.wr_data = tx_data[g];
    assign tx_ready[g] = tx_q.wr_ready;
    assign tx_q.rd_ready = tx_take;
    assign rx_q.wr_valid = rx_push_ff;
    assign rx_q.wr_data = rx_word_ff;
    assign rx_q.rd_ready = rx_ready[g];
    assign rx_data[g] = rx_q.rd_data;
    assign rx_valid[g] = rx_q.rd_valid;

    // pin inputs, three stages and agreement filter
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        in_s1_ff <= 1'b1;
        in_s2_ff <= 1'b1;
        in_s3_ff <= 1'b1;
        in_filt_ff <= 1'b1;
        cts_s1_ff <= 1'b1;
        cts_s2_ff <= 1'b1;
        cts_s3_ff <= 1'b1;
        cts_filt_ff <= 1'b1;
      end else begin
        in_s1_ff <= ser_in[g];
        in_s2_ff <= in_s1_ff;
        in_s3_ff <= in_s2_ff;
        if (in_s2_ff == in_s3_ff) begin
          in_filt_ff <= in_s3_ff;
        end
        cts_s1_ff <= cts_n[g];
        cts_s2_ff <= cts_s1_ff;
        cts_s3_ff <= cts_s2_ff;
        if (cts_s2_ff == cts_s3_ff) begin
          cts_filt_ff <= cts_s3_ff;
        end
      end
    end

    always_comb begin
      irda = function_select_register[g][`ASP_FSEL_IRDA_BIT] && (function_select_register[g] != `ASP_FSEL_RS485);
      rs485 = function_select_register[g] == `ASP_FSEL_RS485;
      nbits = rs485 ? 4'h9 : 4'h8;
      use_par = parity_en[g] && !irda;
      half_len = {1'b0, bit_len[16:1]};
      ir_len = 17'((({2'b00, bit_len} << 1) + {2'b00, bit_len}) >> 4);
      if (ir_len == '0) begin
        ir_len = 17'h0_0001;
      end
      rx_line = irda ? ((ir_hold_ff == '0) || (tx_state_ff != asp_pkg::TX_IDLE)) : in_filt_ff;
      tx_take = (tx_state_ff == asp_pkg::TX_IDLE) && tx_q.rd_valid && (!flow_auto_en[g] || !cts_filt_ff);
      tx_end = tick && (tx_cnt_ff >= bit_len - 17'h0_0001);
      rx_mid = tick && (rx_cnt_ff == half_len);
      rx_end = tick && (rx_cnt_ff >= bit_len - 17'h0_0001);
    end

    // infrared pulse decoder, holds a zero for one bit
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        ir_hold_ff <= '0;
      end else if (!in_filt_ff) begin
        ir_hold_ff <= bit_len;
      end else if (tick && ir_hold_ff != '0) begin
        ir_hold_ff <= ir_hold_ff - 17'h0_0001;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        tx_state_ff <= asp_pkg::TX_IDLE;
        tx_shift_ff <= '0;
        tx_bit_ff <= '0;
        tx_cnt_ff <= '0;
        tx_line_ff <= 1'b1;
        tx_par_ff <= 1'b0;
      end else begin
        if (tx_state_ff != asp_pkg::TX_IDLE && tick) begin
          tx_cnt_ff <= tx_end ? '0 : tx_cnt_ff + 17'h0_0001;
        end
        case (tx_state_ff)
          asp_pkg::TX_IDLE: begin
            if (tx_take) begin
              tx_shift_ff <= tx_q.rd_data;
              tx_state_ff <= asp_pkg::TX_START;
              tx_cnt_ff <= '0;
              tx_line_ff <= 1'b0;
              tx_par_ff <= 1'b0;
            end
          end
          asp_pkg::TX_START: begin
            if (tx_end) begin
              tx_state_ff <= asp_pkg::TX_DATA;
              tx_bit_ff <= '0;
              tx_line_ff <= tx_shift_ff[0];
            end
          end
          asp_pkg::TX_DATA: begin
            if (tx_end) begin
              tx_par_ff <= tx_par_ff ^ tx_line_ff;
              if (tx_bit_ff == nbits - 4'h1) begin
                tx_state_ff <= use_par ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
                tx_line_ff <= use_par ? (tx_par_ff ^ tx_line_ff) : 1'b1;
              end else begin
                tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
                tx_line_ff <= tx_shift_ff[1];
                tx_bit_ff <= tx_bit_ff + 4'h1;
              end
            end
          end
          asp_pkg::TX_PAR: begin
            if (tx_end) begin
              tx_state_ff <= asp_pkg::TX_STOP;
              tx_line_ff <= 1'b1;
            end
          end
          asp_pkg::TX_STOP: begin
            if (tx_end) begin
              tx_state_ff <= asp_pkg::TX_IDLE;
            end
          end
          default: begin
            tx_state_ff <= asp_pkg::TX_IDLE;
            tx_line_ff <= 1'b1;
          end
        endcase
      end
    end

    // infrared encoder, short pulse per zero bit
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        ser_out_ff <= 1'b1;
      end else begin
        ser_out_ff <= irda ? (!tx_line_ff && tx_cnt_ff < ir_len) : tx_line_ff;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        rx_state_ff <= asp_pkg::RX_IDLE;
        rx_shift_ff <= '0;
        rx_word_ff <= '0;
        rx_bit_ff <= '0;
        rx_cnt_ff <= '0;
        rx_par_ff <= 1'b0;
        rx_zero_ff <= 1'b1;
        rx_perr_ff <= 1'b0;
        rx_push_ff <= 1'b0;
        err_set <= '0;
      end else begin
        rx_push_ff <= 1'b0;
        err_set <= '0;
        if (rx_state_ff != asp_pkg::RX_IDLE && tick) begin
          rx_cnt_ff <= rx_end ? '0 : rx_cnt_ff + 17'h0_0001;
        end
        case (rx_state_ff)
          asp_pkg::RX_IDLE: begin
            if (!rx_line) begin
              rx_state_ff <= asp_pkg::RX_START;
              rx_cnt_ff <= '0;
              rx_shift_ff <= '0;
              rx_par_ff <= 1'b0;
              rx_zero_ff <= 1'b1;
              rx_perr_ff <= 1'b0;
            end
          end
          asp_pkg::RX_START: begin
            if (rx_mid && rx_line) begin
              rx_state_ff <= asp_pkg::RX_IDLE;
            end else if (rx_end) begin
              rx_state_ff <= asp_pkg::RX_DATA;
              rx_bit_ff <= '0;
            end
          end
          asp_pkg::RX_DATA: begin
            if (rx_mid) begin
              rx_shift_ff[rx_bit_ff] <= rx_line;
              rx_par_ff <= rx_par_ff ^ rx_line;
              rx_zero_ff <= rx_zero_ff && !rx_line;
            end
            if (rx_end) begin
              if (rx_bit_ff == nbits - 4'h1) begin
                rx_state_ff <= use_par ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
              end else begin
                rx_bit_ff <= rx_bit_ff + 4'h1;
              end
            end
          end
          asp_pkg::RX_PAR: begin
            if (rx_mid) begin
              rx_perr_ff <= rx_line ^ rx_par_ff;
              rx_zero_ff <= rx_zero_ff && !rx_line;
            end
            if (rx_end) begin
              rx_state_ff <= asp_pkg::RX_STOP;
            end
          end
          asp_pkg::RX_STOP: begin
            if (rx_mid) begin
              rx_state_ff <= asp_pkg::RX_IDLE;
              rx_word_ff <= rx_shift_ff;
              rx_push_ff <= 1'b1;
              err_set[`ASP_ERR_PARITY] <= rx_perr_ff;
              err_set[`ASP_ERR_FRAME] <= !rx_line;
              err_set[`ASP_ERR_BREAK] <= rx_zero_ff && !rx_line;
            end
          end
          default: begin
            rx_state_ff <= asp_pkg::RX_IDLE;
          end
        endcase
      end
    end

    // sticky error flags, set beats clear
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        err_ff <= '0;
        modem_ff <= 1'b0;
        cts_prev_ff <= 1'b1;
      end else begin
        cts_prev_ff <= cts_filt_ff;
        err_ff[2:0] <= (err_ff[2:0] & ~status_clr[g][2:0]) | err_set[2:0];
        err_ff[`ASP_ERR_OVERFLOW] <= (err_ff[`ASP_ERR_OVERFLOW] && !status_clr[g][`ASP_ERR_OVERFLOW])
          || (rx_push_ff && !rx_q.wr_ready);
        modem_ff <= (modem_ff && !status_clr[g][`ASP_CLR_MODEM]) || (cts_prev_ff != cts_filt_ff);
      end
    end

    // idle bit periods with data waiting
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        tout_tick_ff <= '0;
        tout_bits_ff <= '0;
      end else if (rx_q.count == '0 || rx_state_ff != asp_pkg::RX_IDLE || rx_push_ff
          || (rx_q.rd_valid && rx_ready[g])) begin
        tout_tick_ff <= '0;
        tout_bits_ff <= '0;
      end else if (tick) begin
        if (tout_tick_ff >= bit_len - 17'h0_0001) begin
          tout_tick_ff <= '0;
          if (tout_bits_ff != 8'hff) begin
            tout_bits_ff <= tout_bits_ff + 8'h01;
          end
        end else begin
          tout_tick_ff <= tout_tick_ff + 17'h0_0001;
        end
      end
    end

    always_comb begin
      src[`ASP_SRC_TX_EMPTY] = (tx_q.count == '0) && (tx_state_ff == asp_pkg::TX_IDLE);
      src[`ASP_SRC_RX_THR] = (rx_q.count != '0) && (rx_q.count >= 4'(rx_trigger_level[g]));
      src[`ASP_SRC_LINE] = |err_ff[2:0];
      src[`ASP_SRC_TOUT] = (rx_tout_bits[g] != '0) && (tout_bits_ff >= rx_tout_bits[g]);
      src[`ASP_SRC_MODEM] = modem_ff;
      src[`ASP_SRC_BUF_ERR] = err_ff[`ASP_ERR_OVERFLOW];
    end
    assign ch_irq[g] = |(src & irq_en[g]);

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        src_ff <= '0;
      end else begin
        src_ff <= src;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        rts_n_ff <= 1'b1;
      end else if (rs485) begin
        rts_n_ff <= (tx_state_ff == asp_pkg::TX_IDLE) && !tx_take;
      end else if (flow_auto_en[g]) begin
        rts_n_ff <= rx_q.count >= 4'(flow_trigger_level[g]);
      end else begin
        rts_n_ff <= 1'b0;
      end
    end

    assign rts_n[g] = rts_n_ff;
    assign ser_out[g] = ser_out_ff;
    assign err_flags[g] = err_ff;
    assign irq_src[g] = src_ff;
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        busy_ff <= '0;
      end else begin
        busy_ff <= {rx_state_ff != asp_pkg::RX_IDLE, tx_state_ff != asp_pkg::TX_IDLE};
      end
    end
    assign tx_busy[g] = busy_ff[0];
    assign rx_busy[g] = busy_ff[1];
  end
endmodule : asp_uart_top
`default_nettype wire

// file: asp_consts.svh
// constants for the dual asynchronous serial port
// Operation
// - mode 0 rate is clock/(16*(divisor+2))
// - mode 1 rate clock/((ext+1)*(divisor+2))
// - mode 2 rate is clock/(divisor+2)
// - fourteen-entry transmit and receive queues per channel
// - six interrupt sources per channel
// - parity, framing, break raise line status
// - four readable receive error flags
// - both channels share one system interrupt
// - status readable anytime without disturbing transfers
// - flow control lines are active low
// - request-to-send asserted before reception permitted
// - deassert request-to-send at flow trigger level
// - transmit only while clear-to-send asserted
// - infrared frames one start, eight data, stop
// - infrared supports rates up to 115.2k
// - infrared never transmits and receives together; the code blanks receive during a send but can start a send mid-reception
// - rs485 selection gives nine-bit characters
// - rs485 request-to-send drives line direction
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
`define ASP_CHANNELS 2
`define ASP_FIFO_DEPTH 14
`define ASP_WORD_W 9
`define ASP_OVERSAMPLE 17'h0_0010
`define ASP_DIV_OFFSET 17'h0_0002
`define ASP_BITLEN_W 17
`define ASP_IRQ_NUM 13
`define ASP_IRQ_VECTOR 29
`define ASP_FSEL_UART 2'h0
`define ASP_FSEL_IRDA_BIT 1
`define ASP_FSEL_RS485 2'h3
`define ASP_SRC_TX_EMPTY 0
`define ASP_SRC_RX_THR 1
`define ASP_SRC_LINE 2
`define ASP_SRC_TOUT 3
`define ASP_SRC_MODEM 4
`define ASP_SRC_BUF_ERR 5
`define ASP_ERR_PARITY 0
`define ASP_ERR_FRAME 1
`define ASP_ERR_BREAK 2
`define ASP_ERR_OVERFLOW 3
`define ASP_CLR_MODEM 4
`endif

// file: asp_pkg.sv
// types shared by the serial port modules
package asp_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } asp_tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } asp_rx_state_e;
endpackage : asp_pkg

// file: asp_stream_if.sv
// write and read sides of one character queue
`timescale 1ns/1ps
`default_nettype none
interface asp_stream_if #(parameter int W = 9, parameter int D = 14);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic [$clog2(D+1)-1:0] count;
  modport fifo (input wr_valid, input wr_data, input rd_ready,
    output wr_ready, output rd_valid, output rd_data, output count);
  modport user (output wr_valid, output wr_data, output rd_ready,
    input wr_ready, input rd_valid, input rd_data, input count);
endinterface : asp_stream_if
`default_nettype wire

// file: asp_fifo.sv
// character queue with registered read side
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(parameter int W = 9, parameter int D = 14) (
  input wire logic clk_sys,
  input wire logic rst_n,
  asp_stream_if.fifo q
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
  logic [CW-1:0] arr_cnt_ff, count_ff;
  logic out_valid_ff, wr_ready_ff;
  logic [W-1:0] out_data_ff;
  logic wr_fire, pop_out, load_out, bypass, arr_rd, arr_wr;
  logic [CW-1:0] nxt_count;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(D-1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  always_comb begin
    wr_fire = q.wr_valid && wr_ready_ff;
    pop_out = out_valid_ff && q.rd_ready;
    load_out = !out_valid_ff || pop_out;
    bypass = load_out && (arr_cnt_ff == '0) && wr_fire;
    arr_rd = load_out && (arr_cnt_ff != '0);
    arr_wr = wr_fire && !bypass;
    nxt_count = CW'(count_ff + CW'(wr_fire) - CW'(pop_out));
  end

  always_ff @(posedge clk_sys) begin
    if (arr_wr) begin
      mem_ff[wr_ptr_ff] <= q.wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      arr_cnt_ff <= '0;
      count_ff <= '0;
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
      wr_ready_ff <= 1'b0;
    end else begin
      if (arr_wr) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (arr_rd) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
        out_data_ff <= mem_ff[rd_ptr_ff];
      end else if (bypass) begin
        out_data_ff <= q.wr_data;
      end
      if (load_out) begin
        out_valid_ff <= arr_rd || bypass;
      end
      arr_cnt_ff <= CW'(arr_cnt_ff + CW'(arr_wr) - CW'(arr_rd));
      count_ff <= nxt_count;
      wr_ready_ff <= nxt_count < CW'(D);
    end
  end

  assign q.wr_ready = wr_ready_ff;
  assign q.rd_valid = out_valid_ff;
  assign q.rd_data = out_data_ff;
  assign q.count = count_ff;
endmodule : asp_fifo
`default_nettype wire

// file: asp_baud.sv
// baud tick generator with three divider modes
`timescale 1ns/1ps
`default_nettype none
`include "asp_consts.svh"
module asp_baud (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic div_x_en,
  input wire logic div_x_one,
  input wire logic [3:0] divider_x,
  input wire logic [15:0] baud_divisor_field,
  output logic tick_ff,
  output logic [16:0] bit_len_ff
);
  logic [16:0] pre_cnt_ff;
  logic [16:0] pre_len;
  logic [16:0] nxt_bit_len;

  always_comb begin
    if (div_x_en && div_x_one) begin
      pre_len = 17'h0_0001;
      nxt_bit_len = 17'(baud_divisor_field) + `ASP_DIV_OFFSET;
    end else if (div_x_en) begin
      pre_len = 17'(baud_divisor_field) + `ASP_DIV_OFFSET;
      nxt_bit_len = 17'(divider_x) + 17'h0_0001;
    end else begin
      pre_len = 17'(baud_divisor_field) + `ASP_DIV_OFFSET;
      nxt_bit_len = `ASP_OVERSAMPLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_cnt_ff <= '0;
      tick_ff <= 1'b0;
      bit_len_ff <= `ASP_OVERSAMPLE;
    end else begin
      bit_len_ff <= nxt_bit_len;
      if (pre_cnt_ff >= pre_len - 17'h0_0001) begin
        pre_cnt_ff <= '0;
        tick_ff <= 1'b1;
      end else begin
        pre_cnt_ff <= pre_cnt_ff + 17'h0_0001;
        tick_ff <= 1'b0;
      end
    end
  end
endmodule : asp_baud
`default_nettype wire

// file: asp_uart_chk.sv
// concurrent checks on the serial port top ports
`timescale 1ns/1ps
`default_nettype none
module asp_uart_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] tx_valid,
  input wire logic [1:0] tx_ready,
  input wire logic [1:0] ser_out,
  input wire logic [1:0] rts_n,
  input wire logic [1:0][3:0] err_flags,
  input wire logic [1:0][5:0] irq_src,
  input wire logic [1:0][5:0] irq_en,
  input wire logic uart_irq_ff,
  input wire logic [1:0][4:0] status_clr,
  input wire logic [1:0] tx_busy,
  input wire logic [1:0] cts_n,
  input wire logic [1:0] flow_auto_en,
  input wire logic [1:0][1:0] function_select_register
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_IRQ_OR: assert property (uart_irq_ff == |((irq_src[0] & $past(irq_en[0])) |
    (irq_src[1] & $past(irq_en[1])))) else $error("system interrupt not or of enabled sources");
  AST_LINE_IRQ: assert property ($rose(err_flags[0][1]) |-> ##[0:2] irq_src[0][2])
    else $error("frame error without line status source");
  AST_BUF_IRQ: assert property ($rose(err_flags[0][3]) |-> ##[0:2] irq_src[0][5])
    else $error("overflow without buffer error source");
  AST_ERR_CLR: assert property ($fell(err_flags[0][1]) |-> $past(status_clr[0][1]) ||
    $past(status_clr[0][1], 2)) else $error("frame error flag lost without clear");
  AST_RTS_LOW: assert property (!flow_auto_en[0] && function_select_register[0] != 2'h3 |=> !rts_n[0])
    else $error("rts not asserted without auto flow");
  AST_CTS_HOLD: assert property ((flow_auto_en[0] && cts_n[0] && !tx_busy[0]) [*6] |=> !tx_busy[0])
    else $error("transmit started while cts high");
  AST_START_LOW: assert property ($rose(tx_busy[0]) && function_select_register[0] == 2'h0
    |-> ##[0:2] !ser_out[0]) else $error("no low start bit");
  AST_IDLE_HI: assert property (!tx_busy[0] [*3] ##0 function_select_register[0] == 2'h0 |-> ser_out[0])
    else $error("line not high while idle");
  AST_TX_READY: assert property ($fell(tx_ready[0]) |-> $past(tx_valid[0]) || $past(tx_valid[0], 2) ||
    $past(tx_valid[0], 3)) else $error("tx ready dropped without a write");
endmodule : asp_uart_chk
`default_nettype wire

// file: asp_line_peer.sv
// serial peer model: sends frames to the port and captures its frames
`timescale 1ns/1ps
`default_nettype none
module asp_line_peer (
  input wire logic clk_sys,
  input wire logic rts_n,
  input wire logic rx_line,
  output logic tx_line
);
  initial tx_line = 1'b1;
  // wait rts low, frame lsb first
  task automatic send(input logic [7:0] b, input logic stp, input int n);
    logic [9:0] f;
    int k;
    f = {stp, b, 1'b0};
    k = 0;
    while (rts_n && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys) tx_line <= f[i];
      repeat (n - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys) tx_line <= 1'b1;
    repeat (2 * n) @(posedge clk_sys);
  endtask : send
  task automatic grab(output logic [7:0] b, input int n);
    int k;
    b = 8'hxx;
    k = 0;
    while (rx_line && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    if (k < 3000) begin
      repeat (n + n / 2) @(negedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        b[i] = rx_line;
        repeat (n) @(negedge clk_sys);
      end
    end
  endtask : grab
endmodule : asp_line_peer
`default_nettype wire

// file: tb_top.sv
// testbench for the dual serial port top
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; $display("mismatch %0t %s", $time, m); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] div_x_en = 2'h3;
  logic [1:0] div_x_one = 2'h3;
  logic [1:0][3:0] divider_x = '0;
  logic [1:0][15:0] baud_divisor_field = {16'h0003, 16'h0003};
  logic [1:0][1:0] function_select_register = '0;
  logic [1:0] parity_en = '0;
  logic [1:0] flow_auto_en = '0;
  logic [1:0][3:0] flow_trigger_level = {4'h2, 4'h2};
  logic [1:0][3:0] rx_trigger_level = {4'h1, 4'h1};
  logic [1:0][7:0] rx_tout_bits = {8'h04, 8'h04};
  logic [1:0][5:0] irq_en = '0;
  logic [1:0][4:0] status_clr = '0;
  logic [1:0][8:0] tx_data = '0;
  logic [1:0] tx_valid = '0;
  logic [1:0] rx_ready = '0;
  logic [1:0] cts_n = '0;
  wire logic [1:0] ser_in;
  logic [1:0] tx_ready, ser_out, rts_n, rx_valid, tx_busy, rx_busy;
  logic [1:0][8:0] rx_data;
  logic [1:0][3:0] err_flags;
  logic [1:0][5:0] irq_src;
  logic uart_irq_ff;
  int n_mismatch = 0;
  int n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  assign ser_in[1] = ser_out[0];
  asp_uart_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .div_x_en(div_x_en), .div_x_one(div_x_one),
    .divider_x(divider_x), .baud_divisor_field(baud_divisor_field),
    .function_select_register(function_select_register), .parity_en(parity_en), .flow_auto_en(flow_auto_en),
    .flow_trigger_level(flow_trigger_level), .rx_trigger_level(rx_trigger_level), .rx_tout_bits(rx_tout_bits),
    .irq_en(irq_en), .status_clr(status_clr), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .ser_in(ser_in), .ser_out(ser_out),
    .cts_n(cts_n), .rts_n(rts_n), .err_flags(err_flags), .irq_src(irq_src), .tx_busy(tx_busy),
    .rx_busy(rx_busy), .uart_irq_ff(uart_irq_ff));
  asp_line_peer i_peer (.clk_sys(clk_sys), .rts_n(rts_n[0]), .rx_line(ser_out[0]), .tx_line(ser_in[0]));
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic put(input int ch, input logic [8:0] d, input int lim, output bit ok);
    int k;
    ok = 1'b0;
    k = 0;
    @(posedge clk_sys);
    tx_data[ch] <= d;
    tx_valid[ch] <= 1'b1;
    while (!ok && k < lim) begin
      @(negedge clk_sys);
      ok = tx_ready[ch];
      k++;
    end
    @(posedge clk_sys);
    tx_valid[ch] <= 1'b0;
  endtask : put
  task automatic pop(input int ch, input logic [7:0] e);
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (rx_valid[ch] !== 1'b1 && k < 2000);
    if (rx_valid[ch] !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
    `CHK(rx_data[ch][7:0], e, "received character")
    @(posedge clk_sys) rx_ready[ch] <= 1'b1;
    @(posedge clk_sys) rx_ready[ch] <= 1'b0;
  endtask : pop
  task automatic expect_tx(input logic [7:0] e, input int n);
    logic [7:0] b;
    i_peer.grab(b, n);
    `CHK(b, e, "sent character")
    if (b === 8'hxx) summarize();
  endtask : expect_tx
  initial begin
    bit ok;
    int n_acc;
    int bl[3] = '{16 * (0 + 2), (8 + 1) * (0 + 2), 3 + 2};
    repeat (5) @(posedge clk_sys);
    `CHK(ser_out, 2'h3, "line not idle in reset")
    `CHK(rts_n, 2'h3, "rts asserted in reset")
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    irq_en <= {6'h00, 6'h01};
    repeat (4) @(negedge clk_sys);
    `CHK(uart_irq_ff, 1'b1, "tx empty interrupt")
    @(posedge clk_sys) irq_en <= '0;
    repeat (4) @(negedge clk_sys);
    `CHK(uart_irq_ff, 1'b0, "masked interrupt")
    $display("test irq done");
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_sys);
      div_x_en <= {2{m != 0}};
      div_x_one <= {2{m == 2}};
      divider_x <= {2{4'h8}};
      baud_divisor_field <= {2{(m == 2) ? 16'h0003 : 16'h0000}};
      repeat (4) @(posedge clk_sys);
      put(0, {1'b0, 8'h5A ^ m[7:0]}, 200, ok);
      expect_tx(8'h5A ^ m[7:0], bl[m]);
      pop(1, 8'h5A ^ m[7:0]);
    end
    $display("test baud modes done");
    @(posedge clk_sys);
    flow_auto_en <= 2'h1;
    cts_n <= 2'h1;
    repeat (4) @(posedge clk_sys);
    n_acc = 0;
    for (int i = 0; i < 15; i++) begin
      put(0, 9'(i), 4, ok);
      n_acc += ok;
    end
    `CHK(n_acc, 14, "tx queue depth")
    @(negedge clk_sys);
    `CHK(ser_out[0], 1'b1, "sent while cts high")
    @(posedge clk_sys) cts_n <= 2'h0;
    for (int i = 0; i < 14; i++) pop(1, 8'(i));
    $display("test tx flow done");
    @(negedge clk_sys);
    `CHK(rts_n[0], 1'b0, "rts not asserted when empty")
    i_peer.send(8'h81, 1'b1, 5);
    i_peer.send(8'h42, 1'b1, 5);
    @(negedge clk_sys);
    `CHK(rts_n[0], 1'b1, "rts held at trigger level")
    repeat (40) @(negedge clk_sys);
    `CHK(irq_src[0][3], 1'b1, "rx timeout source")
    `CHK(irq_src[0][1], 1'b1, "rx threshold source")
    pop(0, 8'h81);
    repeat (3) @(negedge clk_sys);
    `CHK(rts_n[0], 1'b0, "rts released below level")
    pop(0, 8'h42);
    $display("test rx flow done");
    @(posedge clk_sys) flow_auto_en <= 2'h0;
    i_peer.send(8'h55, 1'b0, 5);
    `CHK(err_flags[0][1], 1'b1, "frame error")
    `CHK(irq_src[0][2], 1'b1, "line status source")
    i_peer.send(8'h00, 1'b0, 5);
    `CHK(err_flags[0][2], 1'b1, "break")
    @(posedge clk_sys) status_clr <= {5'h00, 5'h07};
    @(posedge clk_sys) status_clr <= '0;
    repeat (3) @(negedge clk_sys);
    `CHK(err_flags[0][2:0], 3'h0, "flags not cleared")
    for (int i = 0; i < 16; i++) i_peer.send(8'(i), 1'b1, 5);
    `CHK(err_flags[0][3], 1'b1, "overflow")
    `CHK(irq_src[0][5], 1'b1, "buffer error source")
    $display("test errors done");
    @(posedge clk_sys) function_select_register <= 4'h2;
    repeat (3) @(negedge clk_sys);
    `CHK(ser_out[0], 1'b0, "infrared idle not low")
    $display("test infrared done");
    summarize();
  end
endmodule : tb_top
bind asp_uart_top asp_uart_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .ser_out(ser_out), .rts_n(rts_n), .err_flags(err_flags), .irq_src(irq_src),
  .irq_en(irq_en), .uart_irq_ff(uart_irq_ff), .status_clr(status_clr), .tx_busy(tx_busy), .cts_n(cts_n),
  .flow_auto_en(flow_auto_en), .function_select_register(function_select_register));
`default_nettype wire
